// ===== pkg/obcd_pkg.sv
// obcd_pkg: option byte map, field layout and decode helpers
// assumes one 40 MHz clock domain and byte-wide option storage
package obcd_pkg;

  localparam logic [15:0] ADDR_READOUT   = 16'h4800;
  localparam logic [15:0] ADDR_BOOTAREA  = 16'h4802;
  localparam logic [15:0] ADDR_PROTAREA  = 16'h4807;
  localparam logic [15:0] ADDR_DOG       = 16'h4808;
  localparam logic [15:0] ADDR_OSC       = 16'h4809;
  localparam logic [15:0] ADDR_BROWN     = 16'h480A;
  localparam logic [15:0] ADDR_LOADER_HI = 16'h480B;
  localparam logic [15:0] ADDR_LOADER_LO = 16'h480C;

  localparam int          OPT_COUNT     = 8;
  localparam int          OPT_AW        = 3;
  localparam logic [2:0]  IDX_READOUT   = 3'h0;
  localparam logic [2:0]  IDX_BOOTAREA  = 3'h1;
  localparam logic [2:0]  IDX_PROTAREA  = 3'h2;
  localparam logic [2:0]  IDX_DOG       = 3'h3;
  localparam logic [2:0]  IDX_OSC       = 3'h4;
  localparam logic [2:0]  IDX_BROWN     = 3'h5;
  localparam logic [2:0]  IDX_LOADER_HI = 3'h6;
  localparam logic [2:0]  IDX_LOADER_LO = 3'h7;
  localparam logic [2:0]  IDX_LAST      = 3'h7;

  localparam logic [7:0]  READOUT_OPEN_KEY = 8'hAA;
  localparam int          DOG_IND_AUTO  = 0;
  localparam int          DOG_IND_HALT  = 1;
  localparam int          DOG_WIN_AUTO  = 2;
  localparam int          DOG_WIN_HALT  = 3;
  localparam int          OSC_FAST_LSB  = 0;
  localparam int          OSC_SLOW_LSB  = 2;
  localparam int          BROWN_EN_BIT  = 0;
  localparam int          BROWN_TH_LSB  = 1;
  localparam int          BROWN_TH_W    = 3;

  localparam int          SETTLE_W      = 13;
  localparam logic [12:0] SETTLE_C0     = 13'h0001;
  localparam logic [12:0] SETTLE_C1     = 13'h0010;
  localparam logic [12:0] SETTLE_C2     = 13'h0200;
  localparam logic [12:0] SETTLE_C3     = 13'h1000;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_DONE = 2'b10
  } obcd_state_t;

  // {hit, index}; unmapped addresses give hit = 0
  function automatic logic [3:0] opt_index(input logic [15:0] a);
    case (a)
      ADDR_READOUT:   opt_index = {1'b1, IDX_READOUT};
      ADDR_BOOTAREA:  opt_index = {1'b1, IDX_BOOTAREA};
      ADDR_PROTAREA:  opt_index = {1'b1, IDX_PROTAREA};
      ADDR_DOG:       opt_index = {1'b1, IDX_DOG};
      ADDR_OSC:       opt_index = {1'b1, IDX_OSC};
      ADDR_BROWN:     opt_index = {1'b1, IDX_BROWN};
      ADDR_LOADER_HI: opt_index = {1'b1, IDX_LOADER_HI};
      ADDR_LOADER_LO: opt_index = {1'b1, IDX_LOADER_LO};
      default:        opt_index = 4'h0;
    endcase
  endfunction

  function automatic logic [12:0] settle_cycles(input logic [1:0] c);
    case (c)
      2'h0:    settle_cycles = SETTLE_C0;
      2'h1:    settle_cycles = SETTLE_C1;
      2'h2:    settle_cycles = SETTLE_C2;
      default: settle_cycles = SETTLE_C3;
    endcase
  endfunction

  // bytes that only the debug link may change
  function automatic logic app_locked(input logic [2:0] i);
    app_locked = (i == IDX_READOUT) || (i == IDX_BOOTAREA) ||
                 (i == IDX_PROTAREA);
  endfunction

endpackage

// ===== rtl/obcd_opt_mem.sv
// obcd_opt_mem: small option byte store, one write and one read port
// assumes unprogrammed bytes read as zero (blank part, no reset)
`timescale 1ns/100ps
module obcd_opt_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             re_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  if (DEPTH > (1 << AW) || DEPTH < 1 || WIDTH < 1) begin : g_bad_size
    $error("obcd_opt_mem: depth does not fit the address width");
  end

  // non-volatile in spirit: left out of reset, powers up blank so
  // a load before the first programming gives zeros, not unknowns
  logic [WIDTH-1:0] mem_r [DEPTH] = '{default: '0};
  logic [WIDTH-1:0] rdata_r;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_r <= mem_r[raddr_i];
    end
  end

  assign rdata_o = rdata_r;

endmodule // obcd_opt_mem

// ===== rtl/obcd_top.sv
// obcd_top: loads option bytes after reset and drives the decoded
// configuration to watchdogs, oscillators, brownout, protection, boot.
// assumes the option port and control levels are on clk_i; the two
// oscillator inputs are foreign and are synchronised here.
`timescale 1ns/100ps
module obcd_top import obcd_pkg::*; #(
  parameter logic [15:0] LOADER_KEY   = 16'h0000,
  parameter logic [7:0]  VECTOR_BLANK = 8'h00
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        opt_wr_i,
  input  wire logic        opt_rd_i,
  input  wire logic        opt_icp_i,
  input  wire logic [15:0] opt_addr_i,
  input  wire logic [7:0]  opt_wdata_i,
  output logic             opt_ready_o,
  output logic             opt_rvalid_o,
  output logic      [7:0]  opt_rdata_o,
  output logic             cfg_valid_o,
  output logic             readout_open_o,
  input  wire logic [7:0]  page_query_i,
  output logic             page_write_protect_o,
  output logic             page_read_protect_o,
  output logic      [7:0]  boot_area_pages_o,
  output logic      [7:0]  protected_area_pages_o,
  input  wire logic        indep_dog_sw_start_i,
  input  wire logic        window_dog_sw_start_i,
  input  wire logic        halt_i,
  input  wire logic        active_halt_i,
  output logic             indep_dog_run_o,
  output logic             window_dog_run_o,
  output logic             window_dog_reset_o,
  output logic      [12:0] fast_osc_settle_count_o,
  output logic      [12:0] slow_osc_settle_count_o,
  input  wire logic [1:0]  osc_clk_i,
  input  wire logic [1:0]  osc_enable_i,
  output logic      [1:0]  osc_stable_o,
  output logic             brownout_enable_o,
  output logic      [2:0]  brownout_threshold_o,
  output logic      [15:0] loader_select_word_o,
  input  wire logic [7:0]  reset_vector_i,
  output logic             boot_to_loader_o
);

  typedef struct packed {
    obcd_state_t           st;
    logic [2:0]            idx;
    logic                  cap;
    logic [2:0]            cap_idx;
    logic [7:0][7:0]       cfg;
    logic                  valid;
    logic                  rvalid;
    logic                  rd_hit;
    logic                  ro_open;
    logic                  wprot;
    logic                  rprot;
    logic                  ind_started;
    logic                  win_started;
    logic                  ind_run;
    logic                  win_run;
    logic                  halt_d;
    logic                  win_rst;
    logic [12:0]           fast_cnt;
    logic [12:0]           slow_cnt;
    logic [1:0][2:0]       osc_sync;
    logic [1:0]            osc_lvl;
    logic [1:0][12:0]      osc_cnt;
    logic [1:0]            osc_stable;
    logic                  boot_loader;
  } obcd_regs_t;

  obcd_regs_t  r;
  obcd_regs_t  n;
  logic        mem_we;
  logic        mem_re;
  logic [2:0]  mem_raddr;
  logic [7:0]  mem_rdata;
  logic [3:0]  dec;
  logic [12:0] target;
  logic        rise;

  obcd_opt_mem #(
    .WIDTH (8),
    .DEPTH (OPT_COUNT),
    .AW    (OPT_AW)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (dec[2:0]),
    .wdata_i (opt_wdata_i),
    .re_i    (mem_re),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  always_comb begin
    n         = r;
    dec       = opt_index(opt_addr_i);
    mem_we    = 1'b0;
    mem_re    = 1'b0;
    mem_raddr = r.idx;
    target    = '0;
    rise      = 1'b0;
    n.cap     = 1'b0;
    n.rvalid  = 1'b0;
    unique case (r.st)
      ST_LOAD: begin
        // one trailing re-read of index 0 is harmless and never captured
        mem_re    = 1'b1;
        n.cap     = 1'b1;
        n.cap_idx = r.idx;
        n.idx     = r.idx + 3'h1;
      end
      ST_DONE: begin
        mem_re    = opt_rd_i;
        mem_raddr = dec[2:0];
        n.rvalid  = opt_rd_i;
        n.rd_hit  = dec[3];
        mem_we    = opt_wr_i && dec[3] &&
                    (opt_icp_i || !app_locked(dec[2:0]));
      end
    endcase
    if (r.cap && r.st == ST_LOAD) begin
      n.cfg[r.cap_idx] = mem_rdata;
      if (r.cap_idx == IDX_LAST) begin
        n.st = ST_DONE;
      end
    end
    n.valid   = (r.st == ST_DONE);
    n.ro_open = (r.cfg[IDX_READOUT] == READOUT_OPEN_KEY);
    n.wprot   = (page_query_i < r.cfg[IDX_BOOTAREA]) ||
                (page_query_i < r.cfg[IDX_PROTAREA]);
    n.rprot   = (page_query_i < r.cfg[IDX_PROTAREA]);
    // dogs never start before the configuration is trusted
    n.ind_started = r.ind_started | (r.valid &
      (r.cfg[IDX_DOG][DOG_IND_AUTO] | indep_dog_sw_start_i));
    n.win_started = r.win_started | (r.valid &
      (r.cfg[IDX_DOG][DOG_WIN_AUTO] | window_dog_sw_start_i));
    n.ind_run = r.ind_started & ~((halt_i | active_halt_i) &
                r.cfg[IDX_DOG][DOG_IND_HALT]);
    n.win_run = r.win_started & ~halt_i;
    n.halt_d  = halt_i;
    n.win_rst = r.win_started & halt_i & ~r.halt_d &
                r.cfg[IDX_DOG][DOG_WIN_HALT];
    n.fast_cnt = settle_cycles(r.cfg[IDX_OSC][OSC_FAST_LSB +: 2]);
    n.slow_cnt = settle_cycles(r.cfg[IDX_OSC][OSC_SLOW_LSB +: 2]);
    for (int i = 0; i < 2; i++) begin
      n.osc_sync[i] = {r.osc_sync[i][1:0], osc_clk_i[i]};
      // a change counts only once the second and third stages agree
      if (r.osc_sync[i][1] == r.osc_sync[i][2]) begin
        n.osc_lvl[i] = r.osc_sync[i][2];
      end
      rise   = n.osc_lvl[i] & ~r.osc_lvl[i];
      target = (i == 0) ? r.fast_cnt : r.slow_cnt;
      if (!osc_enable_i[i] || !r.valid) begin
        n.osc_cnt[i] = '0;
      end else if (rise && r.osc_cnt[i] < target) begin
        n.osc_cnt[i] = r.osc_cnt[i] + 13'h0001;
      end
      n.osc_stable[i] = osc_enable_i[i] & r.valid &
                        (r.osc_cnt[i] >= target);
    end
    if (r.st == ST_DONE && !r.valid) begin
      n.boot_loader = ({r.cfg[IDX_LOADER_HI], r.cfg[IDX_LOADER_LO]} ==
                       LOADER_KEY) || (reset_vector_i == VECTOR_BLANK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r    <= '0;
      r.st <= ST_LOAD;
    end else begin
      r <= n;
    end
  end

  assign opt_ready_o             = (r.st == ST_DONE);
  assign opt_rvalid_o            = r.rvalid;
  assign opt_rdata_o             = r.rd_hit ? mem_rdata : 8'h00;
  assign cfg_valid_o             = r.valid;
  assign readout_open_o          = r.ro_open;
  assign page_write_protect_o    = r.wprot;
  assign page_read_protect_o     = r.rprot;
  assign boot_area_pages_o       = r.cfg[IDX_BOOTAREA];
  assign protected_area_pages_o  = r.cfg[IDX_PROTAREA];
  assign indep_dog_run_o         = r.ind_run;
  assign window_dog_run_o        = r.win_run;
  assign window_dog_reset_o      = r.win_rst;
  assign fast_osc_settle_count_o = r.fast_cnt;
  assign slow_osc_settle_count_o = r.slow_cnt;
  assign osc_stable_o            = r.osc_stable;
  assign brownout_enable_o       = r.cfg[IDX_BROWN][BROWN_EN_BIT];
  assign brownout_threshold_o    =
    r.cfg[IDX_BROWN][BROWN_TH_LSB +: BROWN_TH_W];
  assign loader_select_word_o    =
    {r.cfg[IDX_LOADER_HI], r.cfg[IDX_LOADER_LO]};
  assign boot_to_loader_o        = r.boot_loader;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_ro_open;
    cfg_valid_o |-> (readout_open_o ==
      (r.cfg[IDX_READOUT] == READOUT_OPEN_KEY));
  endproperty
  a_ro_open: assert property (p_ro_open)
    else $error("readout open flag does not match its byte");

  property p_wprot;
    cfg_valid_o && $past(cfg_valid_o) |-> page_write_protect_o ==
      (($past(page_query_i) < boot_area_pages_o) ||
       ($past(page_query_i) < protected_area_pages_o));
  endproperty
  a_wprot: assert property (p_wprot)
    else $error("page write protect wrong for queried page");

  property p_rprot;
    cfg_valid_o && $past(cfg_valid_o) |->
      page_read_protect_o == ($past(page_query_i) < protected_area_pages_o);
  endproperty
  a_rprot: assert property (p_rprot)
    else $error("page read protect wrong for queried page");

  property p_ind_auto;
    cfg_valid_o && r.cfg[IDX_DOG][DOG_IND_AUTO] |=> ##1 r.ind_started;
  endproperty
  a_ind_auto: assert property (p_ind_auto)
    else $error("independent dog did not auto start");

  property p_ind_halt;
    cfg_valid_o && r.ind_started && (halt_i || active_halt_i) &&
      r.cfg[IDX_DOG][DOG_IND_HALT] |=> !indep_dog_run_o;
  endproperty
  a_ind_halt: assert property (p_ind_halt)
    else $error("independent dog ran in halt while told to stop");

  property p_win_auto;
    !r.win_started ##1 r.win_started |->
      $past(r.cfg[IDX_DOG][DOG_WIN_AUTO] || window_dog_sw_start_i);
  endproperty
  a_win_auto: assert property (p_win_auto)
    else $error("window dog started without a cause");

  property p_win_rst;
    r.win_started && halt_i && !$past(halt_i) &&
      r.cfg[IDX_DOG][DOG_WIN_HALT] |=> window_dog_reset_o ##1
      !window_dog_reset_o;
  endproperty
  a_win_rst: assert property (p_win_rst)
    else $error("window dog halt reset not a single pulse");

  property p_settle;
    cfg_valid_o |-> fast_osc_settle_count_o ==
      settle_cycles(r.cfg[IDX_OSC][OSC_FAST_LSB +: 2]) &&
      slow_osc_settle_count_o ==
      settle_cycles(r.cfg[IDX_OSC][OSC_SLOW_LSB +: 2]);
  endproperty
  a_settle: assert property (p_settle)
    else $error("settle cycle count does not match its code");

  property p_app_lock;
    opt_wr_i && !opt_icp_i && dec[3] && app_locked(dec[2:0]) |-> !mem_we;
  endproperty
  a_app_lock: assert property (p_app_lock)
    else $error("application write to a locked byte was applied");

  property p_boot;
    $rose(cfg_valid_o) |-> boot_to_loader_o ==
      ((loader_select_word_o == LOADER_KEY) ||
       ($past(reset_vector_i) == VECTOR_BLANK));
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot path choice wrong after load");

  property p_hold;
    cfg_valid_o |=> cfg_valid_o && $stable(r.cfg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("configuration changed after it was loaded");

endmodule // obcd_top

// ===== bench/obcd_prog_model.sv
// obcd_prog_model: programming side of the option port
// assumes tasks are called from one process, clocked by clk_i
`timescale 1ns/100ps
module obcd_prog_model (
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  input  wire logic        rvalid_i,
  input  wire logic [7:0]  rdata_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic             icp_o,
  output logic      [15:0] addr_o,
  output logic      [7:0]  wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    icp_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end

  task automatic start(input logic [15:0] a);
    @(posedge clk_i);
    #1;
    while (ready_i !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    addr_o = a;
  endtask

  // dbg low marks an application write
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic dbg);
    start(a);
    wdata_o = d;
    icp_o = dbg;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    // released lines show the inverse, not the last value
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic v);
    start(a);
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    v = rvalid_i;
    d = rdata_i;
  endtask
endmodule // obcd_prog_model

// ===== bench/obcd_top_test.sv
// obcd_top_test: loads four option sets and checks the decode
// assumes obcd_top with default parameters, one 40 MHz clock
`timescale 1ns/100ps
module obcd_top_test import obcd_pkg::*;;
  logic        clk, reset, halt, ahalt, isw, wsw, wr, rd, icp;
  logic        ready, rvalid, cfg_valid, ro_open, wp, rp, v;
  logic        irun, wrun, wrst, boot_ldr, bo_en;
  logic [15:0] addr, ldr_word;
  logic [7:0]  wdata, rdata, page, bpages, ppages, vec, d;
  logic [12:0] fcnt, scnt;
  logic [1:0]  oclk, oen, ostable;
  logic [2:0]  bo_th;
  int          failures, checks_done;
  logic [7:0]  t_ro[4]  = '{8'hAA, 8'h55, 8'hAA, 8'h55};
  logic [7:0]  t_ub[4]  = '{8'h00, 8'h01, 8'hFF, 8'h05};
  logic [7:0]  t_pc[4]  = '{8'hFF, 8'h00, 8'h02, 8'h01};
  logic [7:0]  t_dog[4] = '{8'h0F, 8'h00, 8'h05, 8'h0A};
  logic [7:0]  t_bo[4]  = '{8'h01, 8'h0E, 8'h0B, 8'h04};
  logic [7:0]  t_lh[4]  = '{8'h00, 8'h12, 8'h00, 8'hAB};
  logic [7:0]  t_ll[4]  = '{8'h00, 8'h34, 8'h01, 8'h00};
  logic [12:0] t_set[4] = '{13'h0001, 13'h0010, 13'h0200, 13'h1000};

  obcd_prog_model u_prog (.clk_i(clk), .ready_i(ready), .rvalid_i(rvalid),
    .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .icp_o(icp), .addr_o(addr),
    .wdata_o(wdata));

  obcd_top DUT (.clk_i(clk), .reset_i(reset), .opt_wr_i(wr),
    .opt_rd_i(rd), .opt_icp_i(icp), .opt_addr_i(addr),
    .opt_wdata_i(wdata), .opt_ready_o(ready), .opt_rvalid_o(rvalid),
    .opt_rdata_o(rdata), .cfg_valid_o(cfg_valid), .readout_open_o(ro_open),
    .page_query_i(page), .page_write_protect_o(wp),
    .page_read_protect_o(rp), .boot_area_pages_o(bpages),
    .protected_area_pages_o(ppages), .indep_dog_sw_start_i(isw),
    .window_dog_sw_start_i(wsw), .halt_i(halt), .active_halt_i(ahalt),
    .indep_dog_run_o(irun), .window_dog_run_o(wrun),
    .window_dog_reset_o(wrst), .fast_osc_settle_count_o(fcnt),
    .slow_osc_settle_count_o(scnt), .osc_clk_i(oclk), .osc_enable_i(oen),
    .osc_stable_o(ostable), .brownout_enable_o(bo_en),
    .brownout_threshold_o(bo_th), .loader_select_word_o(ldr_word),
    .reset_vector_i(vec), .boot_to_loader_o(boot_ldr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask

  task automatic chk_val(input string n, input logic [15:0] e,
                         input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    reset = 1'b1;
    step(6);
    chk_bit("cfg_valid in reset", 1'b0, cfg_valid);
    reset = 1'b0;
    for (int i = 0; i < 20 && cfg_valid !== 1'b1; i++)
      step(1);
    chk_bit("cfg_valid", 1'b1, cfg_valid);
  endtask

  task automatic q(input logic [7:0] p);
    page = p;
    step(2);
  endtask

  task automatic prog(input int k);
    u_prog.wr(ADDR_READOUT, t_ro[k], 1'b1);
    u_prog.wr(ADDR_BOOTAREA, t_ub[k], 1'b1);
    u_prog.wr(ADDR_PROTAREA, t_pc[k], 1'b1);
    u_prog.wr(ADDR_DOG, t_dog[k], 1'b1);
    u_prog.wr(ADDR_OSC, {4'h0, 2'(k), 2'(3 - k)}, 1'b1);
    u_prog.wr(ADDR_BROWN, t_bo[k], 1'b1);
    u_prog.wr(ADDR_LOADER_HI, t_lh[k], 1'b1);
    u_prog.wr(ADDR_LOADER_LO, t_ll[k], 1'b1);
  endtask

  task automatic check_cfg(input int k);
    chk_bit("readout_open", t_ro[k] == 8'hAA, ro_open);
    chk_val("boot_pages", t_ub[k], bpages);
    chk_val("prot_pages", t_pc[k], ppages);
    chk_val("fast_settle", t_set[3 - k], fcnt);
    chk_val("slow_settle", t_set[k], scnt);
    chk_bit("brownout_enable", t_bo[k][0], bo_en);
    chk_val("brownout_threshold", t_bo[k][3:1], bo_th);
    chk_val("loader_word", {t_lh[k], t_ll[k]}, ldr_word);
    chk_bit("boot_to_loader", {t_lh[k], t_ll[k]} == 0 || k == 1,
            boot_ldr);
    q(t_ub[k]);
    // protected area may also write-protect, so only test clear pages
    if (t_ub[k] >= t_pc[k]) chk_bit("wp at size", 1'b0, wp);
    if (t_ub[k] != 0) begin
      q(t_ub[k] - 8'h01);
      chk_bit("wp below size", 1'b1, wp);
    end
    q(t_pc[k]);
    chk_bit("rp at size", 1'b0, rp);
    if (t_pc[k] != 0) begin
      q(t_pc[k] - 8'h01);
      chk_bit("rp below size", 1'b1, rp);
    end
    chk_bit("indep_run auto", t_dog[k][0], irun);
    chk_bit("window_run auto", t_dog[k][2], wrun);
    isw = 1'b1;
    wsw = 1'b1;
    step(3);
    chk_bit("indep_run sw", 1'b1, irun);
    chk_bit("window_run sw", 1'b1, wrun);
    isw = 1'b0;
    wsw = 1'b0;
    halt = 1'b1;
    step(1);
    chk_bit("window_reset", t_dog[k][3], wrst);
    chk_bit("window_run halt", 1'b0, wrun);
    chk_bit("indep_run halt", !t_dog[k][1], irun);
    step(1);
    chk_bit("window_reset pulse", 1'b0, wrst);
    halt = 1'b0;
    ahalt = 1'b1;
    step(2);
    chk_bit("indep_run active_halt", !t_dog[k][1], irun);
    ahalt = 1'b0;
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    {reset, halt, ahalt, isw, wsw} = 5'h10;
    page = 8'h00;
    vec = 8'h82;
    oclk = 2'h0;
    oen = 2'h0;
    do_reset();
    for (int k = 0; k < 4; k++) begin
      prog(k);
      vec = (k == 1) ? 8'h00 : 8'h82;
      do_reset();
      check_cfg(k);
    end
    u_prog.wr(ADDR_READOUT, 8'hAA, 1'b0);
    u_prog.wr(ADDR_BOOTAREA, 8'h00, 1'b0);
    u_prog.wr(ADDR_DOG, 8'h01, 1'b0);
    u_prog.rd(ADDR_READOUT, d, v);
    chk_bit("rvalid", 1'b1, v);
    chk_val("readout byte", 8'h55, d);
    u_prog.rd(ADDR_BOOTAREA, d, v);
    chk_val("boot byte", 8'h05, d);
    u_prog.rd(ADDR_DOG, d, v);
    chk_val("dog byte", 8'h01, d);
    u_prog.rd(16'h4801, d, v);
    chk_bit("unmapped rvalid", 1'b1, v);
    chk_val("unmapped byte", 8'h00, d);
    chk_bit("readout_open held", 1'b0, ro_open);
    chk_bit("indep_run held", 1'b1, irun);
    do_reset();
    chk_bit("readout_open reload", 1'b0, ro_open);
    chk_val("boot_pages reload", 8'h05, bpages);
    step(3);
    chk_bit("indep_run reload", 1'b1, irun);
    chk_bit("window_run reload", 1'b0, wrun);
    // fast needs 1 edge, slow 4096: six edges split them
    oen = 2'h3;
    repeat (6) begin
      oclk = 2'h3;
      step(4);
      oclk = 2'h0;
      step(4);
    end
    chk_bit("fast stable", 1'b1, ostable[0]);
    chk_bit("slow stable", 1'b0, ostable[1]);
    oen = 2'h0;
    step(3);
    chk_bit("fast disabled", 1'b0, ostable[0]);
    tally_and_finish();
  end

  initial begin
    #200000;
    chk_bit("watchdog", 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule // obcd_top_test
